// ==== verilog/cbl_loader.v ====
// Configuration bitstream loader: active flash, passive and JTAG loading.
// Assumes all pins are asynchronous to ref_clk (50 MHz).
//
// Contract
// (R01) No user mode until configuration memory is fully loaded.
// (R02) Control block writes received bitstream words into configuration memory.
// (R03) Active mode: loader masters the flash transfer itself.
// (R04) Active clock from internal oscillator or external configuration clock.
// (R05) Flash returns bitstream data whenever a read is issued.
// (R06) Active start sends release-from-power-down first.
// (R07) Wait at least 30 us after wake before any read.
// (R08) Fast read from address zero, 24-bit or 32-bit address.
// (R09) Passive: external master drives control, clock and data.
// (R10) Passive master waits 32 us after reset release.
// (R11) Bitstream also accepted through JTAG.
// (R12) Passive x16 and x32 refused when security enabled.
// (R13) Active load starts on config reset rise if bitstream present.
// (R14) Active widths 1, 2, 4, 8 lanes; JTAG 1 lane.
`timescale 1ns/1ps
`default_nettype none
`include "cbl_consts.vh"

module cbl_loader #(
  parameter OSC_DIV = 4,
  parameter DUMMY_CLKS = 8,
  parameter BITSTREAM_WORDS = 1024,
  parameter ADDR_W = 16,
  parameter [7:0] CMD_WAKE = 8'hAB,
  parameter [7:0] CMD_FAST_READ = 8'h0B
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Configuration control pins
  input wire config_reset_n,
  input wire [1:0] modeSel,
  input wire clkSrcExt,
  input wire addr4Byte,
  input wire [1:0] activeWidthSel,
  input wire [2:0] passiveWidthSel,
  input wire securityEn,
  input wire external_config_clock,
  // Serial flash
  output wire flashSck,
  output wire flashCs_n,
  output wire [7:0] flashDataOut,
  output wire [7:0] flashDataOe_n,
  input wire [7:0] flashDataIn,
  // Passive target port
  input wire passClk,
  input wire passCs_n,
  input wire [31:0] passData,
  // JTAG configuration
  input wire tck,
  input wire tdi,
  input wire jtagCfgEn,
  // Configuration memory
  output wire cfgMemWe,
  output wire [ADDR_W-1:0] cfgMemAddr,
  output wire [31:0] cfgMemData,
  // Status
  output wire userMode,
  output wire cfgBusy,
  output wire cfgError,
  output wire widthError
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_WAKE = 4'h1;
  localparam [3:0] S_WAIT = 4'h2;
  localparam [3:0] S_READ = 4'h3;
  localparam [3:0] S_DATA = 4'h4;
  localparam [3:0] S_PASS = 4'h5;
  localparam [3:0] S_JTAG = 4'h6;
  localparam [3:0] S_DONE = 4'h7;
  localparam [3:0] S_ERR = 4'h8;

  localparam integer WAKE_CYC_I = (`CBL_WAKE_WAIT_NS + `CBL_CLK_PERIOD_NS - 1) / `CBL_CLK_PERIOD_NS;
  localparam integer WAKE_LAST_I = WAKE_CYC_I - 1;
  localparam integer RD_LAST3_I = 8 + 24 + DUMMY_CLKS - 1;
  localparam integer RD_LAST4_I = 8 + 32 + DUMMY_CLKS - 1;
  localparam integer OSC_LAST_I = OSC_DIV - 1;
  localparam integer LAST_WORD_I = BITSTREAM_WORDS - 1;
  localparam [11:0] WAKE_LAST = WAKE_LAST_I[11:0];
  localparam [6:0] RD_LAST3 = RD_LAST3_I[6:0];
  localparam [6:0] RD_LAST4 = RD_LAST4_I[6:0];
  localparam [7:0] OSC_LAST = OSC_LAST_I[7:0];
  localparam [ADDR_W-1:0] LAST_WORD = LAST_WORD_I[ADDR_W-1:0];

  // ==========================================================
  // Pin synchronisers
  wire [56:0] lvl;
  cbl_pin_sync #(.W(57)) uSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn({passData, flashDataIn, jtagCfgEn, tdi, tck, passCs_n, passClk, external_config_clock,
            config_reset_n, securityEn, passiveWidthSel, activeWidthSel, addr4Byte, clkSrcExt, modeSel}),
    .pinLvl(lvl)
  );

  wire [1:0] modeS = lvl[1:0];
  wire extS = lvl[2];
  wire addr4S = lvl[3];
  wire [1:0] actWS = lvl[5:4];
  wire [2:0] pasWS = lvl[8:6];
  wire secS = lvl[9];
  wire cfgRstS = lvl[10];
  wire extClkS = lvl[11];
  wire passClkS = lvl[12];
  wire passCsS_n = lvl[13];
  wire tckS = lvl[14];
  wire tdiS = lvl[15];
  wire jtagEnS = lvl[16];
  wire [7:0] flashS = lvl[24:17];
  wire [31:0] passS = lvl[56:25];

  // ==========================================================
  // Edge detection on filtered levels
  reg cfgRstPrev_r;
  reg extClkPrev_r;
  reg passClkPrev_r;
  reg tckPrev_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfgRstPrev_r <= 1'b0;
      extClkPrev_r <= 1'b0;
      passClkPrev_r <= 1'b0;
      tckPrev_r <= 1'b0;
    end else begin
      cfgRstPrev_r <= cfgRstS;
      extClkPrev_r <= extClkS;
      passClkPrev_r <= passClkS;
      tckPrev_r <= tckS;
    end
  end
  wire cfgRstRise = cfgRstS & ~cfgRstPrev_r;
  wire cfgRstFall = ~cfgRstS & cfgRstPrev_r;
  wire extRise = extClkS & ~extClkPrev_r;
  wire passRise = passClkS & ~passClkPrev_r;
  wire tckRise = tckS & ~tckPrev_r;

  // ==========================================================
  // Internal oscillator divider
  reg [7:0] oscCnt_r;
  reg oscTick_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oscCnt_r <= 8'h00;
      oscTick_r <= 1'b0;
    end else begin
      oscTick_r <= (oscCnt_r == OSC_LAST);
      oscCnt_r <= (oscCnt_r == OSC_LAST) ? 8'h00 : oscCnt_r + 8'h01;
    end
  end

  // ==========================================================
  // Loader state
  reg [3:0] state_r;
  reg extSel_r;
  reg addr4_r;
  reg [2:0] wCode_r;
  reg sck_r;
  reg cs_n_r;
  reg [7:0] do_r;
  reg [7:0] oe_n_r;
  reg [39:0] tx_r;
  reg [6:0] bitCnt_r;
  reg [11:0] waitCnt_r;
  reg [31:0] acc_r;
  reg [5:0] accBits_r;
  reg [ADDR_W-1:0] wordCnt_r;
  reg we_r;
  reg [ADDR_W-1:0] memAddr_r;
  reg [31:0] memData_r;
  reg userMode_r;
  reg busy_r;
  reg err_r;
  reg widthErr_r;

  wire spiTick = extSel_r ? extRise : oscTick_r; // R04
  wire spiFall = spiTick & sck_r;
  wire inSpi = (state_r == S_WAKE) | (state_r == S_READ) | (state_r == S_DATA);

  // ==========================================================
  // Sample selection and word assembly
  reg smpEn;
  reg [31:0] smpBits;
  reg [31:0] accNxt;
  always @* begin
    smpEn = 1'b0;
    smpBits = 32'h00000000;
    case (state_r)
      S_DATA: begin
        smpEn = spiFall; // R05
        smpBits = (wCode_r == `CBL_WCODE_X1) ? {31'h00000000, flashS[1]} : {24'h000000, flashS}; // R14
      end
      S_PASS: begin
        smpEn = passRise & ~passCsS_n; // R09
        smpBits = passS;
      end
      S_JTAG: begin
        smpEn = tckRise & jtagEnS; // R11
        smpBits = {31'h00000000, tdiS};
      end
      default: begin
        smpEn = 1'b0;
      end
    endcase
    case (wCode_r)
      3'h0: accNxt = {acc_r[30:0], smpBits[0]};
      3'h1: accNxt = {acc_r[29:0], smpBits[1:0]};
      3'h2: accNxt = {acc_r[27:0], smpBits[3:0]};
      3'h3: accNxt = {acc_r[23:0], smpBits[7:0]};
      3'h4: accNxt = {acc_r[15:0], smpBits[15:0]};
      3'h5: accNxt = smpBits;
      default: accNxt = acc_r;
    endcase
  end
  wire [5:0] accBitsNxt = accBits_r + (6'h01 << wCode_r);
  wire wordFull = (accBitsNxt == `CBL_WORD_BITS);

  // ==========================================================
  // Main sequencer
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      extSel_r <= 1'b0;
      addr4_r <= 1'b0;
      wCode_r <= `CBL_WCODE_X1;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      do_r <= 8'h00;
      oe_n_r <= 8'hFF;
      tx_r <= 40'h0000000000;
      bitCnt_r <= 7'h00;
      waitCnt_r <= 12'h000;
      acc_r <= 32'h00000000;
      accBits_r <= 6'h00;
      wordCnt_r <= {ADDR_W{1'b0}};
      we_r <= 1'b0;
      memAddr_r <= {ADDR_W{1'b0}};
      memData_r <= 32'h00000000;
      userMode_r <= 1'b0;
      busy_r <= 1'b0;
      err_r <= 1'b0;
      widthErr_r <= 1'b0;
    end else begin
      we_r <= 1'b0;
      busy_r <= (state_r != S_IDLE) & (state_r != S_DONE) & (state_r != S_ERR);
      if (inSpi & spiTick) begin
        sck_r <= ~sck_r;
      end
      case (state_r)
        S_IDLE: begin
          if (cfgRstRise) begin // R13
            extSel_r <= extS;
            addr4_r <= addr4S;
            wordCnt_r <= {ADDR_W{1'b0}};
            accBits_r <= 6'h00;
            bitCnt_r <= 7'h00;
            err_r <= 1'b0;
            widthErr_r <= 1'b0;
            case (modeS)
              `CBL_MODE_ACTIVE: begin
                state_r <= S_WAKE; // R03
                wCode_r <= {1'b0, actWS}; // R14
                cs_n_r <= 1'b0;
                tx_r <= {CMD_WAKE, 32'h00000000}; // R06
                do_r <= {7'h00, CMD_WAKE[7]};
                oe_n_r <= 8'hFE;
              end
              `CBL_MODE_PASSIVE: begin
                wCode_r <= pasWS;
                if ((secS & (pasWS >= `CBL_WCODE_X16)) | (pasWS > `CBL_WCODE_X32)) begin
                  state_r <= S_ERR; // R12
                  widthErr_r <= 1'b1;
                end else begin
                  state_r <= S_PASS;
                end
              end
              `CBL_MODE_JTAG: begin
                state_r <= S_JTAG;
                wCode_r <= `CBL_WCODE_X1; // R14
              end
              default: begin
                state_r <= S_ERR;
              end
            endcase
          end
        end
        S_WAKE: begin
          if (spiFall) begin
            tx_r <= {tx_r[38:0], 1'b0};
            do_r <= {7'h00, tx_r[38]};
            bitCnt_r <= bitCnt_r + 7'h01;
            if (bitCnt_r == 7'h07) begin
              cs_n_r <= 1'b1;
              oe_n_r <= 8'hFF;
              waitCnt_r <= 12'h000;
              state_r <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          waitCnt_r <= waitCnt_r + 12'h001;
          if (waitCnt_r == WAKE_LAST) begin // R07
            state_r <= S_READ;
            cs_n_r <= 1'b0;
            bitCnt_r <= 7'h00;
            oe_n_r <= 8'hFE;
            tx_r <= {CMD_FAST_READ, `CBL_FLASH_ADDR_ZERO}; // R08
            do_r <= {7'h00, CMD_FAST_READ[7]};
          end
        end
        S_READ: begin
          if (spiFall) begin
            tx_r <= {tx_r[38:0], 1'b0};
            do_r <= {7'h00, tx_r[38]};
            bitCnt_r <= bitCnt_r + 7'h01;
            if (bitCnt_r == (addr4_r ? RD_LAST4 : RD_LAST3)) begin // R08
              state_r <= S_DATA;
              oe_n_r <= 8'hFF;
              do_r <= 8'h00;
            end
          end
        end
        S_DONE: begin
          userMode_r <= 1'b1; // R01
          cs_n_r <= 1'b1;
        end
        S_ERR: begin
          err_r <= 1'b1;
          cs_n_r <= 1'b1;
        end
        default: begin
          cs_n_r <= cs_n_r;
        end
      endcase
      if (smpEn) begin
        acc_r <= accNxt;
        accBits_r <= wordFull ? 6'h00 : accBitsNxt;
        if (wordFull) begin
          we_r <= 1'b1; // R02
          memAddr_r <= wordCnt_r;
          memData_r <= accNxt;
          wordCnt_r <= wordCnt_r + {{(ADDR_W-1){1'b0}}, 1'b1};
          if ((state_r == S_DATA) & (wordCnt_r == {ADDR_W{1'b0}}) & (accNxt == `CBL_ERASED_WORD)) begin
            state_r <= S_ERR; // R13
            we_r <= 1'b0;
          end else if (wordCnt_r == LAST_WORD) begin
            state_r <= S_DONE; // R01
          end
        end
      end
      if (cfgRstFall) begin
        state_r <= S_IDLE;
        userMode_r <= 1'b0; // R01
        cs_n_r <= 1'b1;
        sck_r <= 1'b0;
        oe_n_r <= 8'hFF;
        do_r <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign flashSck = sck_r;
  assign flashCs_n = cs_n_r;
  assign flashDataOut = do_r;
  assign flashDataOe_n = oe_n_r;
  assign cfgMemWe = we_r;
  assign cfgMemAddr = memAddr_r;
  assign cfgMemData = memData_r;
  assign userMode = userMode_r;
  assign cfgBusy = busy_r;
  assign cfgError = err_r;
  assign widthError = widthErr_r;

endmodule // cbl_loader

`default_nettype wire

// ==== common/cbl_consts.vh ====
// Constants of the configuration bitstream loader.
// Included by the loader files; definitions only.
`ifndef CBL_CONSTS_VH
`define CBL_CONSTS_VH

// ==========================================================
// Timing
`define CBL_CLK_PERIOD_NS 20
`define CBL_WAKE_WAIT_NS 30000
`define CBL_PASS_HOLD_NS 32000

// ==========================================================
// Configuration modes
`define CBL_MODE_ACTIVE 2'h0
`define CBL_MODE_PASSIVE 2'h1
`define CBL_MODE_JTAG 2'h2

// ==========================================================
// Data width codes (lanes = 1 << code)
`define CBL_WCODE_X1 3'h0
`define CBL_WCODE_X16 3'h4
`define CBL_WCODE_X32 3'h5
`define CBL_WORD_BITS 6'h20

// ==========================================================
// Flash address and words
`define CBL_FLASH_ADDR_ZERO 32'h00000000
`define CBL_ERASED_WORD 32'hFFFFFFFF

`endif

// ==== verilog/cbl_pin_sync.v ====
// Three-stage synchroniser with agreement filter for a bus of pins.
// Assumes static or slowly changing inputs relative to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module cbl_pin_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Pins in, filtered levels out
  input wire [W-1:0] pinIn,
  output wire [W-1:0] pinLvl
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] lvl_r;

  // ==========================================================
  // Per-bit stages
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : gSync
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          lvl_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= pinIn[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            lvl_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign pinLvl = lvl_r;

endmodule // cbl_pin_sync

`default_nettype wire

// ==== tb/cbl_loader_chk.sv ====
// Checker of loader flash-pin and memory-port timing.
// Bound to cbl_loader; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module cbl_loader_chk #(
  parameter BITSTREAM_WORDS = 1024,
  parameter ADDR_W = 16,
  parameter [7:0] CMD_WAKE = 8'hAB,
  parameter [7:0] CMD_FAST_READ = 8'h0B
) (
  // Clock, reset, straps
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic config_reset_n,
  input wire logic clkSrcExt,
  // Flash pins
  input wire logic flashSck,
  input wire logic flashCs_n,
  input wire logic [7:0] flashDataOut,
  input wire logic [7:0] flashDataOe_n,
  // Memory port and status
  input wire logic cfgMemWe,
  input wire logic [ADDR_W-1:0] cfgMemAddr,
  input wire logic userMode,
  input wire logic widthError
);
  // ========
  // Select-high counter, last address
  logic [11:0] csHi_r;
  logic [ADDR_W-1:0] lastA_r;
  logic csPrev_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csHi_r <= 12'hFFF;
      lastA_r <= {ADDR_W{1'b0}};
      csPrev_r <= 1'b1;
    end else begin
      csPrev_r <= flashCs_n;
      if (!config_reset_n) csHi_r <= 12'hFFF;
      else if (flashCs_n && !csPrev_r) csHi_r <= 12'h001;
      else if (flashCs_n && csHi_r != 12'hFFF) csHi_r <= csHi_r + 12'h001;
      if (cfgMemWe) lastA_r <= cfgMemAddr;
    end
  end

  // ========
  // Properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_user_last: assert property (
    $rose(userMode) |-> $past(cfgMemAddr) == BITSTREAM_WORDS - 1 && ($past(cfgMemWe) || $past(cfgMemWe, 2)))
    else $error("userMode without last write");
  a_we_pulse: assert property (
    cfgMemWe |=> !cfgMemWe) else $error("write strobe too long");
  a_addr_step: assert property (
    cfgMemWe && cfgMemAddr != 0 |-> cfgMemAddr == lastA_r + 1) else $error("address skipped");
  a_bus_idle: assert property (
    flashCs_n |-> flashDataOe_n == 8'hFF && !flashSck) else $error("flash bus busy while deselected");
  a_sck_half: assert property (
    $rose(flashSck) && !clkSrcExt |-> flashSck [*4] ##1 !flashSck) else $error("clock half period");
  a_wake_first: assert property (
    $fell(flashCs_n) && csHi_r == 12'hFFF |-> flashDataOut[0] == CMD_WAKE[7]) else $error("first frame not wake");
  a_read_gap: assert property (
    $fell(flashCs_n) && csHi_r != 12'hFFF |-> csHi_r >= 12'h5DC && flashDataOut[0] == CMD_FAST_READ[7])
    else $error("read too soon");
  a_width_refuse: assert property (
    widthError |-> !cfgMemWe && !userMode) else $error("refused width loaded");
endmodule // cbl_loader_chk

bind cbl_loader cbl_loader_chk #(
  .BITSTREAM_WORDS(BITSTREAM_WORDS), .ADDR_W(ADDR_W), .CMD_WAKE(CMD_WAKE), .CMD_FAST_READ(CMD_FAST_READ)
) u_chk (
  .ref_clk(ref_clk), .rst(rst), .config_reset_n(config_reset_n), .clkSrcExt(clkSrcExt),
  .flashSck(flashSck), .flashCs_n(flashCs_n), .flashDataOut(flashDataOut), .flashDataOe_n(flashDataOe_n),
  .cfgMemWe(cfgMemWe), .cfgMemAddr(cfgMemAddr), .userMode(userMode), .widthError(widthError)
);

`default_nettype wire

// ==== tb/cbl_flash_model.sv ====
// Serial flash model: logs commands, answers fast reads.
// Word k of the image is base + k.
`timescale 1ns/1ps
`default_nettype none

module cbl_flash_model #(
  parameter DUMMY_CLKS = 8,
  parameter [7:0] CMD_READ = 8'h0B
) (
  // Flash pins
  input wire logic flashSck,
  input wire logic flashCs_n,
  input wire logic [7:0] flashWire,
  output logic [7:0] flashDrv,
  // Setup and observation
  input wire logic addr4Byte,
  input wire logic [1:0] laneCode,
  input wire logic [31:0] base,
  output logic [15:0] cmdLog,
  output logic addrBad
);
  int bitCnt, outBit, n, aEnd;
  logic [31:0] w, t;
  initial begin
    flashDrv = 8'h00;
    cmdLog = 16'h0000;
    addrBad = 1'b0;
  end
  // Frame edges; released lanes flip
  always @(flashCs_n) begin
    bitCnt = 0;
    outBit = 0;
    w = base;
    flashDrv = ~flashDrv;
    if (!flashCs_n) addrBad = 1'b0;
  end
  // Command and address taken on rising edges
  always @(posedge flashSck) begin
    if (!flashCs_n) begin
      aEnd = addr4Byte ? 40 : 32;
      if (bitCnt < 8) cmdLog = {cmdLog[14:0], flashWire[0]};
      else if (bitCnt < aEnd) addrBad = addrBad | flashWire[0];
      bitCnt = bitCnt + 1;
    end
  end
  // Data launched on falling edges, one clock ahead of the next fall that takes it
  always @(negedge flashSck) begin
    if (!flashCs_n) begin
      if (bitCnt >= aEnd + DUMMY_CLKS && cmdLog[7:0] == CMD_READ) begin
        n = 1 << laneCode;
        t = (w << outBit) >> (32 - n);
        flashDrv = ~flashDrv;
        if (n == 1) flashDrv[1] = t[0];
        else flashDrv = (flashDrv & ~((8'h01 << n) - 8'h01)) | t[7:0];
        outBit = outBit + n;
        if (outBit == 32) begin
          outBit = 0;
          w = w + 32'h1;
        end
      end
    end
  end
endmodule // cbl_flash_model

`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the bitstream loader.
// Flash model on the active port; bench is passive and JTAG master.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic ref_clk, rst, config_reset_n, clkSrcExt, addr4Byte, securityEn, external_config_clock, extRun;
  logic passClk, passCs_n, tck, tdi, jtagCfgEn, flashSck, flashCs_n, cfgMemWe;
  logic userMode, cfgBusy, cfgError, widthError, addrBad;
  logic [1:0] modeSel, activeWidthSel;
  logic [2:0] passiveWidthSel;
  logic [7:0] flashDataIn, flashDrv, flashDataOut, flashDataOe_n;
  logic [15:0] cfgMemAddr, cmdLog;
  logic [31:0] passData, cfgMemData, base;
  int mismatches, check_count, wCnt, seed, ph;

  // ========
  // Design, wire resolution, flash
  cbl_loader #(.OSC_DIV(4), .BITSTREAM_WORDS(4)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .config_reset_n(config_reset_n), .modeSel(modeSel),
    .clkSrcExt(clkSrcExt), .addr4Byte(addr4Byte), .activeWidthSel(activeWidthSel),
    .passiveWidthSel(passiveWidthSel), .securityEn(securityEn), .external_config_clock(external_config_clock),
    .flashSck(flashSck), .flashCs_n(flashCs_n), .flashDataOut(flashDataOut), .flashDataOe_n(flashDataOe_n),
    .flashDataIn(flashDataIn), .passClk(passClk), .passCs_n(passCs_n), .passData(passData), .tck(tck),
    .tdi(tdi), .jtagCfgEn(jtagCfgEn), .cfgMemWe(cfgMemWe), .cfgMemAddr(cfgMemAddr), .cfgMemData(cfgMemData),
    .userMode(userMode), .cfgBusy(cfgBusy), .cfgError(cfgError), .widthError(widthError));
  assign flashDataIn = (~flashDataOe_n & flashDataOut) | (flashDataOe_n & flashDrv);
  cbl_flash_model u_flash (
    .flashSck(flashSck), .flashCs_n(flashCs_n), .flashWire(flashDataIn), .flashDrv(flashDrv),
    .addr4Byte(addr4Byte), .laneCode(activeWidthSel), .base(base), .cmdLog(cmdLog), .addrBad(addrBad));

  // ========
  // Clocks and word monitor
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    ph <= ph + 1;
    external_config_clock <= extRun & ph[2];
  end
  always @(negedge ref_clk) begin
    if (cfgMemWe) begin
      chk("addr", 32'(wCnt), {16'h0000, cfgMemAddr});
      chk("data", base + 32'(wCnt), cfgMemData);
      wCnt = wCnt + 1;
    end
  end

  // ========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic send(input logic jt, input int n);
    logic [31:0] w, t;
    for (int k = 0; k < 4; k++) begin
      w = base + 32'(k);
      for (int b = 0; b < 32; b += n) begin
        t = (w << b) >> (32 - n);
        passData <= ($random(seed) & ~((32'h1 << n) - 32'h1)) | t;
        tdi <= t[0];
        repeat (4) @(negedge ref_clk);
        if (jt) tck <= 1'b1;
        else passClk <= 1'b1;
        repeat (4) @(negedge ref_clk);
        tck <= 1'b0;
        passClk <= 1'b0;
      end
    end
  endtask

  task automatic load(input logic [1:0] m, input logic [2:0] pw, input logic [1:0] aw, input logic sec,
                      input logic [31:0] b);
    logic bad, ok;
    int i;
    bad = m == 2'h3 || (m == 2'h1 && (pw >= 3'h6 || (pw >= 3'h4 && sec)));
    ok = !bad && !(m == 2'h0 && b == 32'hFFFFFFFF);
    modeSel <= m;
    passiveWidthSel <= pw;
    activeWidthSel <= aw;
    securityEn <= sec;
    clkSrcExt <= aw[0];
    extRun <= aw[0];
    addr4Byte <= aw[1];
    jtagCfgEn <= m == 2'h2;
    base <= b;
    wCnt = 0;
    repeat (6) @(negedge ref_clk);
    config_reset_n <= 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("busy", 32'(!bad), 32'(cfgBusy));
    if (m != 2'h0 && !bad) begin
      repeat (1600) @(negedge ref_clk);
      passCs_n <= m != 2'h1;
      send(m == 2'h2, m == 2'h2 ? 1 : 1 << pw);
      passCs_n <= 1'b1;
    end
    for (i = 0; i < 40000 && userMode !== 1'b1 && cfgError !== 1'b1; i++) @(negedge ref_clk);
    if (i == 40000) begin
      mismatches++;
      stop_test();
    end
    chk("user", 32'(ok), 32'(userMode));
    chk("error", 32'(!ok), 32'(cfgError));
    chk("width", 32'(bad && m == 2'h1), 32'(widthError));
    chk("words", ok ? 32'h4 : 32'h0, 32'(wCnt));
    if (m == 2'h0) begin
      chk("cmds", 32'h0000AB0B, {16'h0000, cmdLog});
      chk("addr", 32'h0, 32'(addrBad));
    end
    config_reset_n <= 1'b0;
    extRun <= 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("drop", 32'h0, {30'h0, userMode, cfgBusy});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ========
  // Main sequence
  initial begin
    seed = 32'h79b2;
    {config_reset_n, clkSrcExt, addr4Byte, securityEn, external_config_clock, extRun} = 6'h00;
    {passClk, tck, tdi, jtagCfgEn, modeSel, activeWidthSel, passiveWidthSel} = 11'h000;
    {passCs_n, passData, base, ph, wCnt} = 0;
    passCs_n = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    for (int a = 0; a < 4; a++) load(2'h0, 3'h0, a[1:0], 1'b0, $random(seed));
    load(2'h0, 3'h0, 2'h0, 1'b0, 32'hFFFFFFFF);
    for (int i = 0; i < 10; i++) load(2'h1, 3'(i < 8 ? i : i - 4), 2'h0, i < 8 ? !i[0] : i[0], $random(seed));
    load(2'h2, 3'h0, 2'h0, 1'b0, $random(seed));
    load(2'h3, 3'h0, 2'h0, 1'b0, $random(seed));
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
